// File: hw/pcs_cmd_status.sv
`timescale 1ns/1ps
module pcs_cmd_status
    import pcs_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire pcs_cfg_req_t cfg,
    input  wire pcs_bus_evt_t bus_evt,
    input  wire logic         int_pending,
    output logic [31:0]       cfg_rdata,
    output logic              cfg_rvalid,
    output logic              mem_space_en,
    output logic              initiator_en,
    output logic              write_invalidate_en,
    output logic              device_select_line_oe,
    output logic              system_error_line_oe,
    output logic              parity_error_line_oe,
    output logic              int_line_oe
);
    typedef struct packed {
        pcs_cmd_t                    cmd;
        logic                        int_stat;
        logic [PCS_DEVSEL_CYC-1:0]   sel_pipe;
        logic                        serr_oe;
        logic                        perr_oe;
        logic                        int_oe;
        logic [31:0]                 rdata;
        logic                        rvalid;
    } pcs_state_t;

    pcs_state_t     s_reg;
    pcs_state_t     s_next;
    pcs_err_flags_t flags;
    pcs_err_flags_t set_evt;
    pcs_err_flags_t clr_req;
    logic           serr_fire;
    logic           perr_fire;

    function automatic logic hit_word(input pcs_cfg_req_t r);
        return r.addr == PCS_CMD_OFF;
    endfunction

    // Unimplemented command bits are never stored, so they read zero
    function automatic logic [15:0] cmd_word(input pcs_cmd_t c);
        logic [15:0] w;
        w = PCS_CMD_RST;
        w[PCS_CMD_INTBLK_BIT] = c.int_block;
        w[PCS_CMD_SERR_BIT]   = c.syserr_drive_en;
        w[PCS_CMD_PERR_BIT]   = c.parity_report_en;
        w[PCS_CMD_MWI_BIT]    = c.write_invalidate_en;
        w[PCS_CMD_MASTER_BIT] = c.initiator_en;
        w[PCS_CMD_MEM_BIT]    = c.mem_space_en;
        return w;
    endfunction

    function automatic logic [15:0] sts_word(input pcs_err_flags_t f, input logic pend);
        logic [15:0] w;
        w = PCS_STS_RST;
        w[PCS_STS_PAR_BIT]  = f.parity_err_seen;
        w[PCS_STS_SERR_BIT] = f.syserr_signalled;
        w[PCS_STS_MABT_BIT] = f.got_master_abort;
        w[PCS_STS_TREC_BIT] = f.got_target_abort;
        w[PCS_STS_TSIG_BIT] = f.sent_target_abort;
        w[PCS_STS_DPAR_BIT] = f.data_parity_flag;
        w[PCS_STS_INT_BIT]  = pend;
        return w;
    endfunction

    // Line drive is gated by the enable the cycle the error is seen
    assign serr_fire = bus_evt.addr_parity_err_seen && s_reg.cmd.syserr_drive_en;
    assign perr_fire = bus_evt.data_parity_err_seen && s_reg.cmd.parity_report_en;

    always_comb begin
        set_evt = '0;
        set_evt.parity_err_seen   = bus_evt.addr_parity_err_seen || bus_evt.data_parity_err_seen;
        set_evt.syserr_signalled  = serr_fire;
        set_evt.got_master_abort  = bus_evt.master_abort && bus_evt.was_master;
        set_evt.got_target_abort  = bus_evt.target_abort_rcv && bus_evt.was_master;
        set_evt.sent_target_abort = bus_evt.target_abort_sent;
        set_evt.data_parity_flag  = bus_evt.perr_line_seen && bus_evt.was_master
                                    && s_reg.cmd.parity_report_en;
    end

    // Write-one-to-clear on the status half, per byte lane
    always_comb begin
        clr_req = '0;
        if (cfg.wr && hit_word(cfg)) begin
            clr_req.parity_err_seen   = cfg.be[3] && cfg.wdata[16 + PCS_STS_PAR_BIT];
            clr_req.syserr_signalled  = cfg.be[3] && cfg.wdata[16 + PCS_STS_SERR_BIT];
            clr_req.got_master_abort  = cfg.be[3] && cfg.wdata[16 + PCS_STS_MABT_BIT];
            clr_req.got_target_abort  = cfg.be[3] && cfg.wdata[16 + PCS_STS_TREC_BIT];
            clr_req.sent_target_abort = cfg.be[3] && cfg.wdata[16 + PCS_STS_TSIG_BIT];
            clr_req.data_parity_flag  = cfg.be[3] && cfg.wdata[16 + PCS_STS_DPAR_BIT];
        end
    end

    pcs_err_flags u_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set_evt (set_evt),
        .clr_req (clr_req),
        .flags   (flags)
    );

    always_comb begin
        s_next = s_reg;
        if (cfg.wr && hit_word(cfg)) begin
            if (cfg.be[0]) begin
                s_next.cmd.parity_report_en    = cfg.wdata[PCS_CMD_PERR_BIT];
                s_next.cmd.write_invalidate_en = cfg.wdata[PCS_CMD_MWI_BIT];
                s_next.cmd.initiator_en        = cfg.wdata[PCS_CMD_MASTER_BIT];
                s_next.cmd.mem_space_en        = cfg.wdata[PCS_CMD_MEM_BIT];
            end
            if (cfg.be[1]) begin
                s_next.cmd.int_block       = cfg.wdata[PCS_CMD_INTBLK_BIT];
                s_next.cmd.syserr_drive_en = cfg.wdata[PCS_CMD_SERR_BIT];
            end
        end
        s_next.int_stat = int_pending;
        s_next.int_oe   = int_pending && !s_reg.cmd.int_block;
        s_next.serr_oe  = serr_fire;
        s_next.perr_oe  = perr_fire;
        // Medium decode: claim lands on the second edge after the address
        s_next.sel_pipe = {s_reg.sel_pipe[PCS_DEVSEL_CYC-2:0],
                           bus_evt.addr_phase && bus_evt.mem_hit && s_reg.cmd.mem_space_en};
        // I/O hits are never claimed: no I/O space exists
        s_next.rvalid = cfg.rd;
        s_next.rdata  = '0;
        if (cfg.rd && hit_word(cfg)) begin
            s_next.rdata = {sts_word(flags, s_reg.int_stat), cmd_word(s_reg.cmd)};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg_rdata             = s_reg.rdata;
    assign cfg_rvalid            = s_reg.rvalid;
    assign mem_space_en          = s_reg.cmd.mem_space_en;
    assign initiator_en          = s_reg.cmd.initiator_en;
    assign write_invalidate_en   = s_reg.cmd.write_invalidate_en;
    assign device_select_line_oe = s_reg.sel_pipe[PCS_DEVSEL_CYC-1];
    assign system_error_line_oe  = s_reg.serr_oe;
    assign parity_error_line_oe  = s_reg.perr_oe;
    assign int_line_oe           = s_reg.int_oe;

    sequence s_mem_claim;
        bus_evt.addr_phase && bus_evt.mem_hit && mem_space_en;
    endsequence

    sequence s_word_read;
        cfg.rd && (cfg.addr == PCS_CMD_OFF);
    endsequence

    a_cmd_fixed_zero: assert property (@(posedge clock) disable iff (sys_rst)
        s_word_read |=> ((cfg_rdata[15:11] == 5'h00) && !cfg_rdata[9] && !cfg_rdata[7]
                         && !cfg_rdata[5] && !cfg_rdata[3] && !cfg_rdata[0]))
        else $error("hardwired command bit read nonzero");

    a_sts_fixed_bits: assert property (@(posedge clock) disable iff (sys_rst)
        s_word_read |=> ((cfg_rdata[26:25] == PCS_SELECT_TIMING) && cfg_rdata[20] && cfg_rdata[21]
                         && (cfg_rdata[18:16] == 3'h0)))
        else $error("hardwired status bits wrong");

    a_int_blocked: assert property (@(posedge clock) disable iff (sys_rst)
        int_line_oe |-> ($past(int_pending) && !$past(s_reg.cmd.int_block)))
        else $error("interrupt driven while blocked or idle");

    a_int_status_mirror: assert property (@(posedge clock) disable iff (sys_rst)
        (int_pending && s_reg.cmd.int_block) ##1 s_word_read |=> cfg_rdata[16 + PCS_STS_INT_BIT])
        else $error("interrupt status hidden by block");

    a_serr_gated: assert property (@(posedge clock) disable iff (sys_rst)
        system_error_line_oe |-> ($past(s_reg.cmd.syserr_drive_en) && flags.syserr_signalled))
        else $error("system error driven without enable");

    a_perr_gated: assert property (@(posedge clock) disable iff (sys_rst)
        parity_error_line_oe |-> $past(s_reg.cmd.parity_report_en))
        else $error("parity error driven without enable");

    a_parity_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.addr_parity_err_seen || bus_evt.data_parity_err_seen) |=> flags.parity_err_seen)
        else $error("parity error not recorded");

    a_devsel_medium: assert property (@(posedge clock) disable iff (sys_rst)
        s_mem_claim |-> ##PCS_DEVSEL_CYC device_select_line_oe)
        else $error("device select not at medium timing");

    a_no_claim_off: assert property (@(posedge clock) disable iff (sys_rst)
        device_select_line_oe |-> $past(mem_space_en, 2) && $past(bus_evt.mem_hit, 2))
        else $error("cycle claimed with memory space off");

    sequence s_cmd_write_lo;
        cfg.wr && (cfg.addr == PCS_CMD_OFF) && cfg.be[0];
    endsequence

    sequence s_cmd_write_hi;
        cfg.wr && (cfg.addr == PCS_CMD_OFF) && cfg.be[1];
    endsequence

    sequence s_other_read;
        cfg.rd && (cfg.addr != PCS_CMD_OFF);
    endsequence

    a_mem_en_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_lo |=> (mem_space_en == $past(cfg.wdata[PCS_CMD_MEM_BIT])))
        else $error("memory enable not written");

    a_master_en_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_lo |=> (initiator_en == $past(cfg.wdata[PCS_CMD_MASTER_BIT])))
        else $error("initiator enable not written");

    a_mwi_en_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_lo |=> (write_invalidate_en == $past(cfg.wdata[PCS_CMD_MWI_BIT])))
        else $error("write invalidate enable not written");

    a_perr_en_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_lo |=> (s_reg.cmd.parity_report_en == $past(cfg.wdata[PCS_CMD_PERR_BIT])))
        else $error("parity report enable not written");

    a_serr_en_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_hi |=> (s_reg.cmd.syserr_drive_en == $past(cfg.wdata[PCS_CMD_SERR_BIT])))
        else $error("system error enable not written");

    a_intblk_write: assert property (@(posedge clock) disable iff (sys_rst)
        s_cmd_write_hi |=> (s_reg.cmd.int_block == $past(cfg.wdata[PCS_CMD_INTBLK_BIT])))
        else $error("interrupt block not written");

    a_cmd_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !(cfg.wr && (cfg.addr == PCS_CMD_OFF)) |=> $stable(s_reg.cmd))
        else $error("command changed without a write");

    a_reset_outputs: assert property (@(posedge clock)
        sys_rst |=> (!mem_space_en && !initiator_en && !write_invalidate_en && !int_line_oe && !cfg_rvalid))
        else $error("outputs not cleared by reset");

    a_reset_flags: assert property (@(posedge clock)
        sys_rst |=> ((flags == '0) && !s_reg.cmd.int_block && !s_reg.cmd.syserr_drive_en))
        else $error("state not cleared by reset");

    a_rvalid_follows: assert property (@(posedge clock) disable iff (sys_rst)
        cfg.rd |=> cfg_rvalid)
        else $error("read not answered");

    a_rvalid_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg.rd |=> (!cfg_rvalid && (cfg_rdata == 32'h0)))
        else $error("read answer without a read");

    a_other_read: assert property (@(posedge clock) disable iff (sys_rst)
        s_other_read |=> (cfg_rdata == 32'h0))
        else $error("unmapped read not zero");

    a_sts_low_zero: assert property (@(posedge clock) disable iff (sys_rst)
        s_word_read |=> (cfg_rdata[23:22] == 2'h0))
        else $error("fixed zero status bits set");

    a_cmd_readback: assert property (@(posedge clock) disable iff (sys_rst)
        s_word_read |=> ((cfg_rdata[PCS_CMD_MEM_BIT] == $past(mem_space_en))
                         && (cfg_rdata[PCS_CMD_MASTER_BIT] == $past(initiator_en))
                         && (cfg_rdata[PCS_CMD_MWI_BIT] == $past(write_invalidate_en))))
        else $error("command readback wrong");

    a_flag_readback: assert property (@(posedge clock) disable iff (sys_rst)
        s_word_read |=> (cfg_rdata[31:27] == $past({flags.parity_err_seen, flags.syserr_signalled,
                         flags.got_master_abort, flags.got_target_abort, flags.sent_target_abort})))
        else $error("status flag readback wrong");

    a_serr_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.addr_parity_err_seen && s_reg.cmd.syserr_drive_en) |=> (flags.syserr_signalled && system_error_line_oe))
        else $error("system error not signalled");

    a_serr_cause: assert property (@(posedge clock) disable iff (sys_rst)
        system_error_line_oe |-> $past(bus_evt.addr_parity_err_seen))
        else $error("system error without address parity error");

    a_perr_drive: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.data_parity_err_seen && s_reg.cmd.parity_report_en) |=> parity_error_line_oe)
        else $error("parity error line not driven");

    a_perr_cause: assert property (@(posedge clock) disable iff (sys_rst)
        parity_error_line_oe |-> $past(bus_evt.data_parity_err_seen))
        else $error("parity error line without data parity error");

    a_master_abort_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.master_abort && bus_evt.was_master) |=> flags.got_master_abort)
        else $error("master abort not recorded");

    a_abort_recv_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.target_abort_rcv && bus_evt.was_master) |=> flags.got_target_abort)
        else $error("received target abort not recorded");

    a_abort_sent_flag: assert property (@(posedge clock) disable iff (sys_rst)
        bus_evt.target_abort_sent |=> flags.sent_target_abort)
        else $error("sent target abort not recorded");

    a_dpar_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.perr_line_seen && bus_evt.was_master && s_reg.cmd.parity_report_en) |=> flags.data_parity_flag)
        else $error("data parity flag not recorded");

    a_dpar_gated: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(flags.data_parity_flag) |-> $past(bus_evt.perr_line_seen && bus_evt.was_master
                                                && s_reg.cmd.parity_report_en))
        else $error("data parity flag set without cause");

    a_serr_flag_gate: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(flags.syserr_signalled) |-> $past(s_reg.cmd.syserr_drive_en))
        else $error("system error flag set while disabled");

    a_int_open: assert property (@(posedge clock) disable iff (sys_rst)
        (int_pending && !s_reg.cmd.int_block) |=> int_line_oe)
        else $error("unblocked interrupt not driven");

    a_devsel_cause: assert property (@(posedge clock) disable iff (sys_rst)
        device_select_line_oe |-> $past(bus_evt.addr_phase, 2))
        else $error("device select without address phase");

    a_no_io_claim: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_evt.addr_phase && bus_evt.io_hit && !bus_evt.mem_hit) |-> ##2 !device_select_line_oe)
        else $error("I/O cycle claimed");
endmodule

// File: hw/pcs_err_flags.sv
`timescale 1ns/1ps
module pcs_err_flags
    import pcs_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           sys_rst,
    input  wire pcs_err_flags_t set_evt,
    input  wire pcs_err_flags_t clr_req,
    output pcs_err_flags_t      flags
);
    typedef struct packed {
        pcs_err_flags_t flags;
    } pcs_flag_state_t;

    pcs_flag_state_t s_reg;
    pcs_flag_state_t s_next;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        s_next = s_reg;
        s_next.flags = (s_reg.flags & ~clr_req) | set_evt;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign flags = s_reg.flags;

    a_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
        (set_evt != '0) |=> ((flags & $past(set_evt)) == $past(set_evt)))
        else $error("flag event lost");

    a_clear_holds: assert property (@(posedge clock) disable iff (sys_rst)
        ((clr_req == '0) && (set_evt == '0)) |=> (flags == $past(flags)))
        else $error("flag changed without cause");
endmodule

// File: include/pcs_pkg.sv
// Notes on behaviour
// - Command bits 15..11 read as zero and ignore writes.
// - Command bit 10 set blocks the interrupt output; resets to zero.
// - No fast back-to-back generation; command bit 9 reads zero.
// - Command bit 8 read-write, reset zero; system-error line only driven while set.
// - Address/data stepping unsupported; command bit 7 reads zero.
// - Command bit 6 read-write, reset zero; parity-error line only driven while set.
// - No palette snooping; command bit 5 reads zero.
// - Command bit 4 read-write, reset zero; permits write-and-invalidate as master.
// - Special cycles never answered; command bit 3 reads zero.
// - Command bit 2 read-write, reset zero; mastering only while set.
// - Command bit 1 read-write, reset zero; memory cycles claimed only while set.
// - No I/O space; command bit 0 reads zero, I/O cycles never claimed.
// - Status bit 15 set on any detected address or data parity error.
// - Status bit 14 set when system error actually signalled while enabled.
// - Status bit 13 set when own master cycle ends in master abort.
// - Status bit 12 set when own master cycle is target-aborted.
// - Status bit 11 set when function as target signals target abort.
// - Status bits 10..9 read 01b; device select asserted with medium timing.
// - Status bit 8 set on parity line seen, own master transfer, reporting enabled.
// - Status bit 4 reads one: capabilities list present.
// - Status bit 3 shows pending interrupt; line asserted only if unblocked.
package pcs_pkg;

    localparam logic [7:0]  PCS_CMD_OFF       = 8'h04;
    localparam logic [7:0]  PCS_STS_OFF       = 8'h06;
    localparam logic [15:0] PCS_CMD_RST       = 16'h0000;
    localparam logic [15:0] PCS_STS_RST       = 16'h0230;

    localparam int PCS_CMD_MEM_BIT     = 1;
    localparam int PCS_CMD_MASTER_BIT  = 2;
    localparam int PCS_CMD_MWI_BIT     = 4;
    localparam int PCS_CMD_PERR_BIT    = 6;
    localparam int PCS_CMD_SERR_BIT    = 8;
    localparam int PCS_CMD_INTBLK_BIT  = 10;

    localparam int PCS_STS_INT_BIT     = 3;
    localparam int PCS_STS_CAP_BIT     = 4;
    localparam int PCS_STS_66M_BIT     = 5;
    localparam int PCS_STS_DPAR_BIT    = 8;
    localparam int PCS_STS_TIM_LSB     = 9;
    localparam int PCS_STS_TSIG_BIT    = 11;
    localparam int PCS_STS_TREC_BIT    = 12;
    localparam int PCS_STS_MABT_BIT    = 13;
    localparam int PCS_STS_SERR_BIT    = 14;
    localparam int PCS_STS_PAR_BIT     = 15;

    localparam logic [1:0]  PCS_SELECT_TIMING = 2'h1;
    localparam int          PCS_DEVSEL_CYC    = 2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  be;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pcs_cfg_req_t;

    typedef struct packed {
        logic addr_phase;
        logic mem_hit;
        logic io_hit;
        logic addr_parity_err_seen;
        logic data_parity_err_seen;
        logic perr_line_seen;
        logic was_master;
        logic master_abort;
        logic target_abort_rcv;
        logic target_abort_sent;
    } pcs_bus_evt_t;

    typedef struct packed {
        logic parity_err_seen;
        logic syserr_signalled;
        logic got_master_abort;
        logic got_target_abort;
        logic sent_target_abort;
        logic data_parity_flag;
    } pcs_err_flags_t;

    typedef struct packed {
        logic int_block;
        logic syserr_drive_en;
        logic parity_report_en;
        logic write_invalidate_en;
        logic initiator_en;
        logic mem_space_en;
    } pcs_cmd_t;

endpackage

// File: verif/pcs_bus_agent.sv
`timescale 1ns/1ps
module pcs_bus_agent
    import pcs_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    select_oe,
    input  wire logic    syserr_oe,
    input  wire logic    parity_oe,
    output pcs_bus_evt_t bus_evt,
    output logic         device_select_line,
    output logic         system_error_line,
    output logic         parity_error_line
);
    // Pulled-up lines, low only while the function pulls
    assign device_select_line = ~select_oe;
    assign system_error_line  = ~syserr_oe;
    assign parity_error_line  = ~parity_oe;

    initial bus_evt = '0;

    // One event per call, held across exactly one taking edge
    task automatic pulse(input pcs_bus_evt_t e);
        @(posedge clock);
        #1;
        bus_evt = e;
        @(posedge clock);
        #1;
        bus_evt = '0;
    endtask
endmodule

// File: verif/pcs_cmd_status_tb.sv
`timescale 1ns/1ps
module pcs_cmd_status_tb
    import pcs_pkg::*;
;
    logic         clock;
    logic         sys_rst;
    pcs_cfg_req_t cfg;
    pcs_bus_evt_t bus_evt;
    logic         int_pending;
    logic [31:0]  cfg_rdata;
    logic         cfg_rvalid;
    logic [2:0]   en_out;
    logic         sel_oe;
    logic         serr_oe;
    logic         perr_oe;
    logic         int_line_oe;
    logic         sel_line;
    logic         serr_line;
    logic         perr_line;
    logic [2:0]   low;
    int           err_total;
    int           n_tests;

    pcs_cmd_status u_pcs_cmd_status (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .cfg                   (cfg),
        .bus_evt               (bus_evt),
        .int_pending           (int_pending),
        .cfg_rdata             (cfg_rdata),
        .cfg_rvalid            (cfg_rvalid),
        .mem_space_en          (en_out[0]),
        .initiator_en          (en_out[1]),
        .write_invalidate_en   (en_out[2]),
        .device_select_line_oe (sel_oe),
        .system_error_line_oe  (serr_oe),
        .parity_error_line_oe  (perr_oe),
        .int_line_oe           (int_line_oe)
    );

    pcs_bus_agent u_pcs_bus_agent (
        .clock              (clock),
        .select_oe          (sel_oe),
        .syserr_oe          (serr_oe),
        .parity_oe          (perr_oe),
        .bus_evt            (bus_evt),
        .device_select_line (sel_line),
        .system_error_line  (serr_line),
        .parity_error_line  (perr_line)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr_at(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        #1;
        cfg = '{wr: 1'b1, rd: 1'b0, be: be, addr: a, wdata: d};
        @(posedge clock);
        #1;
        cfg.wr = 1'b0;
    endtask

    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        wr_at(PCS_CMD_OFF, be, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clock);
        #1;
        cfg.rd   = 1'b1;
        cfg.addr = a;
        @(posedge clock);
        #1;
        cfg.rd = 1'b0;
        check({name, " valid"}, {31'h0, cfg_rvalid}, 32'h1);
        check(name, cfg_rdata, exp);
    endtask

    // Lines pulled low over the three cycles after an event
    task automatic watch(input logic [2:0] exp, input string name);
        low = 3'h0;
        repeat (3) begin
            low = low | {~sel_line, ~serr_line, ~perr_line};
            @(posedge clock);
            #1;
        end
        check(name, {29'h0, low}, {29'h0, exp});
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
    endtask

    initial begin
        #50000;
        err_total++;
        give_verdict();
    end

    initial begin
        err_total   = 0;
        n_tests     = 0;
        cfg         = '0;
        int_pending = 1'b0;
        do_reset();
        rd(PCS_CMD_OFF, 32'h0230_0000, "reset");
        rd(8'h08, 32'h0000_0000, "unmapped");
        wr(4'h3, 32'h0000_FFFF);
        rd(PCS_CMD_OFF, 32'h0230_0556, "hardwired");
        check("enables", {29'h0, en_out}, 32'h7);
        // Memory enabled before any claim is offered
        u_pcs_bus_agent.pulse(10'h300);
        watch(3'h4, "mem claim");
        u_pcs_bus_agent.pulse(10'h280);
        watch(3'h0, "io claim");
        u_pcs_bus_agent.pulse(10'h040);
        watch(3'h2, "addr parity");
        rd(PCS_CMD_OFF, 32'hC230_0556, "serr flags");
        wr_at(8'h08, 4'hF, 32'hFFFF_FFFF);
        rd(PCS_CMD_OFF, 32'hC230_0556, "unmapped write");
        wr(4'hC, 32'h0000_0000);
        rd(PCS_CMD_OFF, 32'hC230_0556, "write zero");
        wr(4'hC, 32'hC000_0000);
        rd(PCS_CMD_OFF, 32'h0230_0556, "clear");
        u_pcs_bus_agent.pulse(10'h038);
        watch(3'h1, "data parity");
        rd(PCS_CMD_OFF, 32'h8330_0556, "dpar flags");
        u_pcs_bus_agent.pulse(10'h00C);
        u_pcs_bus_agent.pulse(10'h00A);
        u_pcs_bus_agent.pulse(10'h001);
        rd(PCS_CMD_OFF, 32'hBB30_0556, "aborts");
        wr(4'hC, 32'hFFFF_0000);
        rd(PCS_CMD_OFF, 32'h0230_0556, "clear all");
        wr(4'h1, 32'h0000_0000);
        rd(PCS_CMD_OFF, 32'h0230_0500, "low lane");
        wr(4'h2, 32'h0000_00FF);
        rd(PCS_CMD_OFF, 32'h0230_0000, "high lane");
        wr(4'h3, 32'h0000_0400);
        check("enables off", {29'h0, en_out}, 32'h0);
        u_pcs_bus_agent.pulse(10'h300);
        watch(3'h0, "no claim");
        u_pcs_bus_agent.pulse(10'h040);
        watch(3'h0, "serr off");
        u_pcs_bus_agent.pulse(10'h038);
        watch(3'h0, "perr off");
        rd(PCS_CMD_OFF, 32'h8230_0400, "gated flags");
        int_pending = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("int blocked", {31'h0, int_line_oe}, 32'h0);
        rd(PCS_CMD_OFF, 32'h8238_0400, "int status");
        wr(4'h3, 32'h0000_0000);
        @(posedge clock);
        #1;
        check("int open", {31'h0, int_line_oe}, 32'h1);
        int_pending = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check("int gone", {31'h0, int_line_oe}, 32'h0);
        wr(4'h3, 32'h0000_0006);
        do_reset();
        rd(PCS_CMD_OFF, 32'h0230_0000, "second reset");
        give_verdict();
    end
endmodule
